// *** src/rtp_pins.sv ***
// rtc output pins: slow clock, alarm/wave pin, reset supervisor, stop flag
// assumes oscillator, supply, reset pin and bus pins are asynchronous
`timescale 1ns/100ps
`include "rtp_defines.svh"
module rtp_pins #(
    parameter int P_REC_CYC = `RTP_T_REC_MS * `RTP_CYC_PER_MS, // recovery and pulse
    parameter int P_PBDB_CYC = `RTP_T_PBDB_MS * `RTP_CYC_PER_MS, // debounce
    parameter int P_OSF_CYC = `RTP_T_OSF_MS * `RTP_CYC_PER_MS // stop detection
) (
    input wire logic sys_clk, // 50 MHz clock
    input wire logic rst_b, // sync reset, active low
    input wire logic vcc_good, // primary supply above power_fail_threshold
    input wire logic osc_in, // 32.768 kHz oscillator
    input wire logic alarm1_match, // alarm 1 match pulse, same clock
    input wire logic alarm2_match, // alarm 2 match pulse, same clock
    input wire logic scl_in, // serial clock pin
    input wire logic sda_in, // serial data pin level
    output logic sda_out, // serial data drive value
    output logic sda_oe_b, // low while pulling data low
    output logic slow_clock_out, // slow clock drive value
    output logic slow_clock_out_oe_b, // low while pulling low
    output logic alarm_irq_wave_out, // shared pin drive value
    output logic alarm_irq_wave_oe_b, // low while pulling low
    input wire logic rst_pin_in, // reset pin level
    output logic rst_pin_out, // reset pin drive value
    output logic rst_pin_oe_b, // low while pulling reset low
    output logic oscillator_stop_flag // stop flag copy
);
    import rtp_pkg::*;

    localparam logic [`RTP_CNT_W-1:0] REC_LAST = `RTP_CNT_W'(P_REC_CYC - 1);
    localparam logic [`RTP_CNT_W-1:0] PBDB_LAST = `RTP_CNT_W'(P_PBDB_CYC - 1);
    localparam logic [`RTP_CNT_W-1:0] OSF_LAST = `RTP_CNT_W'(P_OSF_CYC - 1);

    rtp_reg_if rif ();
    rtp_sup_t sup_r, sup_nxt;
    logic [4:0] meta_r, sync_r;
    logic osc_d_r, wave_r;
    logic [13:0] hz_cnt_r;
    logic [`RTP_CNT_W-1:0] sup_cnt_r, sup_cnt_nxt, idle_cnt_r;
    logic [7:0] ctrl_r, stat_r, stat_nxt;
    logic clk32_oe_b_r, irq_oe_b_r, rst_oe_b_r;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // two stages; only sync_r is read by logic
    always_ff @(posedge sys_clk) begin
        meta_r <= {vcc_good, osc_in, scl_in, sda_in, rst_pin_in};
        sync_r <= meta_r;
    end
    wire vgood_s = sync_r[4];
    wire osc_s = sync_r[3];
    wire rpin_s = sync_r[0];
    wire osc_rise = osc_s & ~osc_d_r;
    wire osc_edge = osc_s ^ osc_d_r;

    // bus slave keeps running in every supervisor state
    rtp_i2c_slave u_i2c (
        .sys_clk (sys_clk),
        .rst_b (rst_b),
        .scl_s (sync_r[2]),
        .sda_s (sync_r[1]),
        .sda_oe_b (sda_oe_b),
        .rif (rif.bus)
    );

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    wire ctrl_wr = rif.wr & (rif.addr == `RTP_CTRL_ADDR);
    wire stat_wr = rif.wr & (rif.addr == `RTP_STAT_ADDR);
    wire oscillator_disable_bit = ctrl_r[`RTP_CTRL_OSCILLATOR_DISABLE_BIT];
    wire irq_or_wave_select = ctrl_r[`RTP_CTRL_IRQ_OR_WAVE_SELECT];
    wire en32 = stat_r[`RTP_STAT_EN32];
    wire osc_stopped = (idle_cnt_r == OSF_LAST);
    // flag bits clear on a written 0; a hardware set in the same cycle wins
    wire [7:0] keep_m = stat_wr ? rif.wdata : 8'hff;
    assign rif.rdata = (rif.addr == `RTP_CTRL_ADDR) ? ctrl_r :
                       (rif.addr == `RTP_STAT_ADDR) ? stat_r : 8'h00;

    always_comb begin
        stat_nxt = stat_r;
        stat_nxt[`RTP_STAT_OSF] = osc_stopped | (stat_r[`RTP_STAT_OSF] & keep_m[`RTP_STAT_OSF]);
        stat_nxt[`RTP_STAT_A1F] = alarm1_match | (stat_r[`RTP_STAT_A1F] & keep_m[`RTP_STAT_A1F]);
        stat_nxt[`RTP_STAT_A2F] = alarm2_match | (stat_r[`RTP_STAT_A2F] & keep_m[`RTP_STAT_A2F]);
        if (stat_wr) begin
            stat_nxt[`RTP_STAT_EN32] = rif.wdata[`RTP_STAT_EN32];
        end
    end

    // reset value leaves interrupt mode on, alarms off
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl_r <= `RTP_CTRL_RST;
            stat_r <= `RTP_STAT_RST;
        end else begin
            ctrl_r <= ctrl_wr ? rif.wdata : ctrl_r;
            stat_r <= stat_nxt;
        end
    end

    // ------------------------------------------------------------
    // timebase and stop detection
    // ------------------------------------------------------------
    // idle count saturates so a stopped oscillator keeps setting the flag
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            osc_d_r <= 1'b0;
            idle_cnt_r <= '0;
            hz_cnt_r <= 14'h0000;
            wave_r <= 1'b1;
        end else begin
            osc_d_r <= osc_s;
            idle_cnt_r <= osc_edge ? '0 : (osc_stopped ? idle_cnt_r : idle_cnt_r + 1'b1);
            if (osc_rise) begin
                hz_cnt_r <= (hz_cnt_r == `RTP_HALF_1HZ) ? 14'h0000 : hz_cnt_r + 14'h0001;
                wave_r <= (hz_cnt_r == `RTP_HALF_1HZ) ? ~wave_r : wave_r;
            end
        end
    end

    // ------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------
    wire irq_active = (stat_r[`RTP_STAT_A1F] & ctrl_r[`RTP_CTRL_A1IE]) |
                      (stat_r[`RTP_STAT_A2F] & ctrl_r[`RTP_CTRL_A2IE]);
    wire clk32_oe_b_nxt = ~(en32 & ~osc_s);
    wire irq_oe_b_nxt = irq_or_wave_select ? ~irq_active : wave_r;
    wire rst_drive = (sup_r == SUP_PFAIL) | (sup_r == SUP_HOLD) | (sup_r == SUP_PULSE);

    always_ff @(posedge sys_clk) begin
        clk32_oe_b_r <= rst_b ? clk32_oe_b_nxt : 1'b1;
        irq_oe_b_r <= rst_b ? irq_oe_b_nxt : 1'b1;
        rst_oe_b_r <= rst_b ? ~rst_drive : 1'b0;
    end

    assign sda_out = 1'b0;
    assign slow_clock_out = 1'b0;
    assign alarm_irq_wave_out = 1'b0;
    assign rst_pin_out = 1'b0;
    assign slow_clock_out_oe_b = clk32_oe_b_r;
    assign alarm_irq_wave_oe_b = irq_oe_b_r;
    assign rst_pin_oe_b = rst_oe_b_r;
    assign oscillator_stop_flag = stat_r[`RTP_STAT_OSF];

    // ------------------------------------------------------------
    // reset supervisor
    // ------------------------------------------------------------
    // one counter serves recovery, debounce and pulse; they never overlap
    always_comb begin
        sup_nxt = sup_r;
        sup_cnt_nxt = sup_cnt_r + 1'b1;
        case (sup_r)
            SUP_PFAIL: begin
                sup_cnt_nxt = '0;
                if (vgood_s) begin
                    sup_nxt = oscillator_disable_bit ? SUP_RUN : SUP_HOLD;
                end
            end
            SUP_HOLD, SUP_PULSE: if (sup_cnt_r == REC_LAST) begin
                sup_nxt = SUP_RUN;
            end
            SUP_RUN: begin
                sup_cnt_nxt = '0;
                if (!rpin_s) begin
                    sup_nxt = SUP_DEB;
                end
            end
            SUP_DEB: begin
                if (rpin_s) begin
                    sup_nxt = SUP_RUN; // bounce restarts the wait
                end else if (sup_cnt_r == PBDB_LAST) begin
                    sup_nxt = SUP_PULSE;
                    sup_cnt_nxt = '0;
                end
            end
            default: sup_nxt = SUP_PFAIL;
        endcase
        if (!vgood_s) begin
            sup_nxt = SUP_PFAIL;
            sup_cnt_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        sup_r <= rst_b ? sup_nxt : SUP_PFAIL;
        sup_cnt_r <= rst_b ? sup_cnt_nxt : '0;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    clk_gate_a: assert property (!en32 |=> slow_clock_out_oe_b)
        else $error("slow clock driven while disabled");
    wave_mode_a: assert property (!irq_or_wave_select |=> alarm_irq_wave_oe_b == $past(wave_r))
        else $error("shared pin not following square wave");
    irq_hold_a: assert property (irq_or_wave_select && irq_active |=> !alarm_irq_wave_oe_b)
        else $error("alarm interrupt not asserted");
    pfail_drive_a: assert property (!vgood_s |=> ##1 !rst_pin_oe_b)
        else $error("reset not driven in power fail");
    rec_end_a: assert property (sup_r == SUP_HOLD && vgood_s && sup_cnt_r == REC_LAST
        |=> sup_r == SUP_RUN ##1 rst_pin_oe_b)
        else $error("reset not released after recovery");
    bypass_a: assert property (sup_r == SUP_PFAIL && vgood_s && oscillator_disable_bit |=> sup_r == SUP_RUN)
        else $error("recovery not bypassed");
    pb_pulse_a: assert property (sup_r == SUP_DEB && !rpin_s && vgood_s
        && sup_cnt_r == PBDB_LAST |=> sup_r == SUP_PULSE ##1 !rst_pin_oe_b)
        else $error("pushbutton pulse missing");
    osf_set_a: assert property (osc_stopped |=> stat_r[`RTP_STAT_OSF])
        else $error("stop flag not set");
    osf_early_a: assert property (!$past(osc_stopped) && !$past(stat_r[`RTP_STAT_OSF])
        |-> !stat_r[`RTP_STAT_OSF])
        else $error("stop flag set early");
    a1_keep_a: assert property (stat_r[`RTP_STAT_A1F] && !stat_wr |=> stat_r[`RTP_STAT_A1F])
        else $error("alarm flag lost");

    pb_cov: cover property (sup_r == SUP_DEB ##1 sup_r == SUP_PULSE);
    osf_cov: cover property (osc_stopped);
    irq_cov: cover property (irq_or_wave_select && irq_active);
    wave_cov: cover property (!irq_or_wave_select && $rose(wave_r));
endmodule : rtp_pins

// *** src/rtp_defines.svh ***
// constants for the rtc output pin and reset supervisor block
// assumes a 50 MHz sys_clk; the millisecond counts below are derived from it, RTP_HALF_1HZ from the oscillator
// Contract
// - slow clock pin toggles at oscillator rate, 50% duty, only when enabled.
// - select bit 0 puts a 1Hz square wave on the shared pin.
// - select bit 1 pulls the shared pin low on an enabled alarm match.
// - after reset select bit is 1 and both alarm enables are 0.
// - reset pin driven low while the primary supply is below threshold.
// - reset released after the supply stays good for the recovery interval.
// - reset active interval is 250 ms.
// - with oscillator disable bit set, recovery delay is skipped.
// - serial bus and timekeeping keep running whatever the reset pin level.
// - low on reset pin is debounced, then answered by a reset pulse.
// - stop flag set only after oscillator stopped for the detection interval; reset also loads it set (RTP_STAT_RST 8'h88).
// - stop detection interval typically 125 ms, at most 200 ms.
// - serial bus up to 400 kHz fast mode, standard mode also accepted.
`ifndef RTP_DEFINES_SVH
`define RTP_DEFINES_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define RTP_CTRL_ADDR 8'h0e
`define RTP_STAT_ADDR 8'h0f
`define RTP_CTRL_RST 8'h04
`define RTP_STAT_RST 8'h88
`define RTP_CTRL_OSCILLATOR_DISABLE_BIT 7
`define RTP_CTRL_IRQ_OR_WAVE_SELECT 2
`define RTP_CTRL_A2IE 1
`define RTP_CTRL_A1IE 0
`define RTP_STAT_OSF 7
`define RTP_STAT_EN32 3
`define RTP_STAT_A2F 1
`define RTP_STAT_A1F 0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define RTP_CLK_MHZ 50
`define RTP_CYC_PER_MS (`RTP_CLK_MHZ * 1000)
`define RTP_T_REC_MS 250
`define RTP_T_PBDB_MS 250
`define RTP_T_OSF_MS 125
`define RTP_T_OSF_MAX_MS 200
`define RTP_CNT_W 24
`define RTP_HALF_1HZ 14'h3fff
// bus address value is arbitrary
`define RTP_I2C_ADDR 7'h51

`endif

// *** src/rtp_pkg.sv ***
// types shared by the rtc pin block and its serial slave
// assumes nothing beyond a SystemVerilog compiler
package rtp_pkg;
    // reset supervisor states
    typedef enum logic [4:0] {
        SUP_PFAIL = 5'b00001,
        SUP_HOLD = 5'b00010,
        SUP_RUN = 5'b00100,
        SUP_DEB = 5'b01000,
        SUP_PULSE = 5'b10000
    } rtp_sup_t;
    // serial slave states
    typedef enum logic [6:0] {
        I2C_IDLE = 7'b0000001,
        I2C_ADDR = 7'b0000010,
        I2C_AACK = 7'b0000100,
        I2C_WR = 7'b0001000,
        I2C_WACK = 7'b0010000,
        I2C_RD = 7'b0100000,
        I2C_RACK = 7'b1000000
    } rtp_i2c_t;
endpackage : rtp_pkg

// *** src/rtp_reg_if.sv ***
// register access carrier between serial slave and register file
// assumes both ends run on sys_clk
`timescale 1ns/100ps
interface rtp_reg_if;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport bus (output wr, output addr, output wdata, input rdata);
    modport regs (input wr, input addr, input wdata, output rdata);
endinterface : rtp_reg_if

// *** src/rtp_i2c_slave.sv ***
// serial register slave: pointer byte, then auto-incrementing data
// assumes scl and sda already synchronised to sys_clk
`timescale 1ns/100ps
`include "rtp_defines.svh"
module rtp_i2c_slave (
    input wire logic sys_clk, // system clock
    input wire logic rst_b, // sync reset, active low
    input wire logic scl_s, // synchronised serial clock
    input wire logic sda_s, // synchronised serial data
    output logic sda_oe_b, // low while pulling data low
    rtp_reg_if.bus rif // register access
);
    import rtp_pkg::*;

    rtp_i2c_t st_r;
    logic scl_d_r, sda_d_r, rw_r, first_r, drive_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r, tx_r, ptr_r;

    // ------------------------------------------------------------
    // bus condition decode
    // ------------------------------------------------------------
    // 50 MHz sampling gives >60 samples per 400 kHz bit
    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
    wire byte_done = (cnt_r == 4'h8);
    wire addr_hit = (sh_r[7:1] == `RTP_I2C_ADDR);

    assign sda_oe_b = ~drive_r;
    assign rif.addr = ptr_r;
    assign rif.wdata = sh_r;

    // edge history
    always_ff @(posedge sys_clk) begin
        scl_d_r <= rst_b ? scl_s : 1'b1;
        sda_d_r <= rst_b ? sda_s : 1'b1;
    end

    // byte engine; sample on rise, change data on fall
    always_ff @(posedge sys_clk) begin
        rif.wr <= 1'b0;
        if (!rst_b || stop_c) begin
            st_r <= I2C_IDLE;
            drive_r <= 1'b0;
            cnt_r <= 4'h0;
            if (!rst_b) begin
                ptr_r <= 8'h00;
                sh_r <= 8'h00;
                tx_r <= 8'h00;
                rw_r <= 1'b0;
                first_r <= 1'b0;
            end
        end else if (start_c) begin
            st_r <= I2C_ADDR;
            drive_r <= 1'b0;
            cnt_r <= 4'h0;
            first_r <= 1'b1;
        end else if (scl_rise) begin
            if (st_r == I2C_ADDR || st_r == I2C_WR) begin
                sh_r <= {sh_r[6:0], sda_s};
                cnt_r <= cnt_r + 4'h1;
            end else if (st_r == I2C_RD) begin
                cnt_r <= cnt_r + 4'h1;
            end else if (st_r == I2C_RACK) begin
                rw_r <= ~sda_s; // master ack keeps the read going
            end
        end else if (scl_fall) begin
            case (st_r)
                I2C_ADDR: if (byte_done) begin
                    st_r <= addr_hit ? I2C_AACK : I2C_IDLE;
                    drive_r <= addr_hit;
                    rw_r <= sh_r[0];
                end
                I2C_AACK: begin
                    cnt_r <= 4'h0;
                    st_r <= rw_r ? I2C_RD : I2C_WR;
                    drive_r <= rw_r & ~rif.rdata[7];
                    tx_r <= {rif.rdata[6:0], 1'b0};
                end
                I2C_WR: if (byte_done) begin
                    st_r <= I2C_WACK;
                    drive_r <= 1'b1;
                    if (first_r) begin
                        ptr_r <= sh_r;
                    end else begin
                        rif.wr <= 1'b1;
                    end
                end
                I2C_WACK: begin
                    st_r <= I2C_WR;
                    drive_r <= 1'b0;
                    cnt_r <= 4'h0;
                    first_r <= 1'b0;
                    // pointer byte keeps the written pointer; data bytes advance it
                    if (!first_r) begin
                        ptr_r <= ptr_r + 8'h01;
                    end
                end
                I2C_RD: begin
                    if (byte_done) begin
                        st_r <= I2C_RACK;
                        drive_r <= 1'b0;
                        ptr_r <= ptr_r + 8'h01;
                    end else begin
                        drive_r <= ~tx_r[7];
                        tx_r <= {tx_r[6:0], 1'b0};
                    end
                end
                I2C_RACK: begin
                    cnt_r <= 4'h0;
                    st_r <= rw_r ? I2C_RD : I2C_IDLE;
                    drive_r <= rw_r & ~rif.rdata[7];
                    tx_r <= {rif.rdata[6:0], 1'b0};
                end
                default: st_r <= I2C_IDLE;
            endcase
        end
    end
endmodule : rtp_i2c_slave

// *** verification/rtp_host_model.sv ***
// serial bus master standing in for the host controller
// assumes the bench resolves the sda wire and calls tasks just after a posedge
`timescale 1ns/100ps
module rtp_host_model (
    input wire logic sys_clk, // bench clock
    input wire logic sda_in, // resolved sda wire
    output logic scl, // serial clock, high while idle
    output logic sda_drv_b // low while pulling sda low
);
    // ------------------------------------------------------------
    // bit and frame level
    // ------------------------------------------------------------
    // 8 cycles a bit, 160 ns; long low phase so acks are released before scl rises
    initial begin
        scl = 1'b1;
        sda_drv_b = 1'b1;
    end
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // start or repeated start: sda falls while scl stays high
    task start_c;
        tick(1);
        sda_drv_b <= 1'b1;
        tick(7);
        scl <= 1'b1;
        tick(4);
        sda_drv_b <= 1'b0;
        tick(4);
        scl <= 1'b0;
    endtask : start_c
    // stop: sda rises while scl high; scl then stands still
    task stop_c;
        tick(1);
        sda_drv_b <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(4);
        sda_drv_b <= 1'b1;
        tick(4);
    endtask : stop_c
    // data set in scl low, wire sampled late in scl high
    task xfer_bit(input logic b, output logic r);
        tick(1);
        sda_drv_b <= b;
        tick(5);
        scl <= 1'b1;
        tick(1);
        r = sda_in;
        tick(1);
        scl <= 1'b0;
    endtask : xfer_bit
    task xfer_byte(input logic [7:0] d, input logic ack_b, output logic [7:0] r,
                   output logic nack);
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r[i]);
        end
        xfer_bit(ack_b, nack);
    endtask : xfer_byte
    // ------------------------------------------------------------
    // register transfers
    // ------------------------------------------------------------
    task wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
            output logic nack);
        logic [7:0] r;
        logic n0, n1, n2;
        start_c;
        xfer_byte({dev, 1'b0}, 1'b1, r, n0);
        xfer_byte(ptr, 1'b1, r, n1);
        xfer_byte(d, 1'b1, r, n2);
        stop_c;
        nack = n0 | n1 | n2;
    endtask : wr
    // pointer write, repeated start, one byte read closed by a nack
    task rd(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d,
            output logic nack);
        logic [7:0] r;
        logic n0, n1, n2, n3;
        start_c;
        xfer_byte({dev, 1'b0}, 1'b1, r, n0);
        xfer_byte(ptr, 1'b1, r, n1);
        start_c;
        xfer_byte({dev, 1'b1}, 1'b1, r, n2);
        xfer_byte(8'hff, 1'b1, d, n3);
        stop_c;
        nack = n0 | n1 | n2;
    endtask : rd
endmodule : rtp_host_model

// *** verification/test_rtc_output_pins_and_reset.sv ***
// self-checking bench for the rtc output pins and reset supervisor
// assumes rtp_pins with short counts and the host model on the serial pins
`timescale 1ns/100ps
`include "rtp_defines.svh"
module test_rtc_output_pins_and_reset;
    localparam int REC = 20;
    localparam int PBDB = 20;
    localparam int OSCILLATOR_STOP_FLAG = 40;
    localparam int WAVE = 16384 * 4;
    logic sys_clk, rst_b, vcc_good, osc_in, alarm1_match, alarm2_match, pb_b, osc_run;
    logic [1:0] osc_cnt;
    logic scl, sda_drv_b, sda_out, sda_oe_b, slow_clock_out, slow_clock_out_oe_b;
    logic alarm_irq_wave_out, alarm_irq_wave_oe_b, rst_pin_out, rst_pin_oe_b;
    logic oscillator_stop_flag, nk;
    int num_errors, n_tests, wd, n, t0;
    // open-drain wires: pullups plus every party's drive
    wire sda_w = sda_drv_b & (sda_oe_b | sda_out);
    wire rst_w = pb_b & (rst_pin_oe_b | rst_pin_out);
    rtp_pins #(.P_REC_CYC(REC), .P_PBDB_CYC(PBDB), .P_OSF_CYC(OSCILLATOR_STOP_FLAG)) i_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .vcc_good(vcc_good), .osc_in(osc_in),
        .alarm1_match(alarm1_match), .alarm2_match(alarm2_match), .scl_in(scl),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
        .slow_clock_out(slow_clock_out), .slow_clock_out_oe_b(slow_clock_out_oe_b),
        .alarm_irq_wave_out(alarm_irq_wave_out), .alarm_irq_wave_oe_b(alarm_irq_wave_oe_b),
        .rst_pin_in(rst_w), .rst_pin_out(rst_pin_out), .rst_pin_oe_b(rst_pin_oe_b),
        .oscillator_stop_flag(oscillator_stop_flag));
    rtp_host_model i_host (.sys_clk(sys_clk), .sda_in(sda_w), .scl(scl),
        .sda_drv_b(sda_drv_b));
    // ------------------------------------------------------------
    // clock, oscillator, watchdog
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // oscillator scaled to 4 cycles so the 1 Hz divider ends within the run
    always @(posedge sys_clk) begin
        if (osc_run) begin
            osc_cnt <= osc_cnt + 2'h1;
            osc_in <= osc_cnt[1];
        end
    end
    always @(posedge sys_clk) begin
        wd <= wd + 1;
        if (wd == 95000) begin
            num_errors++;
            $display("BAD t=%0t timeout got=%h exp=%h", $time, wd, 95000);
            close_out;
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic pin(input int s);
        case (s)
            0: pin = rst_pin_oe_b;
            // pin level: released drive reads high, driven value otherwise
            1: pin = alarm_irq_wave_oe_b | alarm_irq_wave_out;
            2: pin = slow_clock_out_oe_b | slow_clock_out;
            default: pin = oscillator_stop_flag;
        endcase
    endfunction : pin
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task chk_rng(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng
    // bounded wait for a level; c is the cycles it took
    task wait_lvl(input int s, input logic lvl, input int lim, output int c);
        c = 0;
        while (pin(s) !== lvl && c < lim) begin
            @(posedge sys_clk);
            c++;
        end
    endtask : wait_lvl
    task cnt_low(input int s, input int win, output int c);
        c = 0;
        repeat (win) begin
            @(posedge sys_clk);
            if (pin(s) === 1'b0) c++;
        end
    endtask : cnt_low
    task reg_wr(input logic [7:0] ptr, input logic [7:0] d);
        i_host.wr(`RTP_I2C_ADDR, ptr, d, nk);
        chk8({7'h00, nk}, 8'h00);
    endtask : reg_wr
    task reg_rd(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(`RTP_I2C_ADDR, ptr, d, nk);
        chk8({7'h00, nk}, 8'h00);
        chk8(d, exp);
    endtask : reg_rd
    task pulse(input int which);
        if (which == 1) alarm1_match <= 1'b1;
        else alarm2_match <= 1'b1;
        @(posedge sys_clk);
        alarm1_match <= 1'b0;
        alarm2_match <= 1'b0;
    endtask : pulse
    task close_out;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {rst_b, alarm1_match, alarm2_match, osc_in, osc_cnt} = '0;
        {vcc_good, pb_b, osc_run} = 3'b111;
        {num_errors, n_tests, wd} = '0;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        t0 = wd;
        chk8({7'h00, rst_pin_oe_b}, 8'h00);
        wait_lvl(0, 1'b1, 60, n);
        chk_rng(n, REC, REC + 8);
        reg_rd(`RTP_CTRL_ADDR, 8'h04);
        reg_rd(`RTP_STAT_ADDR, 8'h88);
        chk8({7'h00, alarm_irq_wave_oe_b}, 8'h01);
        reg_wr(8'h05, 8'h5a);
        reg_rd(8'h05, 8'h00);
        i_host.wr(7'h52, `RTP_CTRL_ADDR, 8'h00, nk);
        chk8({7'h00, nk}, 8'h01);
        $display("test reset and bus done");
        // wave starts high and first falls after 16384 rising oscillator edges
        reg_wr(`RTP_CTRL_ADDR, 8'h00);
        chk8({7'h00, alarm_irq_wave_oe_b}, 8'h01);
        wait_lvl(1, 1'b0, 70000, n);
        chk_rng(wd - t0, WAVE - 8, WAVE + 8);
        $display("test square wave done");
        // disabled alarm stays quiet, enabled one latches until cleared
        reg_wr(`RTP_CTRL_ADDR, 8'h05);
        pulse(2);
        cnt_low(1, 20, n);
        chk_rng(n, 0, 0);
        pulse(1);
        cnt_low(1, 100, n);
        chk_rng(n, 98, 100);
        reg_rd(`RTP_STAT_ADDR, 8'h8b);
        reg_wr(`RTP_STAT_ADDR, 8'h8a);
        chk8({7'h00, alarm_irq_wave_oe_b}, 8'h01);
        reg_wr(`RTP_CTRL_ADDR, 8'h06);
        cnt_low(1, 4, n);
        chk_rng(n, 3, 4);
        $display("test alarm done");
        cnt_low(2, 64, n);
        chk_rng(n, 30, 34);
        reg_wr(`RTP_STAT_ADDR, 8'h00);
        cnt_low(2, 64, n);
        chk_rng(n, 0, 0);
        chk8({7'h00, oscillator_stop_flag}, 8'h00);
        osc_run <= 1'b0;
        wait_lvl(3, 1'b1, 80, n);
        chk_rng(n, OSCILLATOR_STOP_FLAG, OSCILLATOR_STOP_FLAG + 8);
        osc_run <= 1'b1;
        $display("test slow clock and stop flag done");
        vcc_good <= 1'b0;
        wait_lvl(0, 1'b0, 8, n);
        chk_rng(n, 0, 5);
        reg_rd(`RTP_CTRL_ADDR, 8'h06);
        vcc_good <= 1'b1;
        wait_lvl(0, 1'b1, 60, n);
        chk_rng(n, REC, REC + 8);
        reg_wr(`RTP_CTRL_ADDR, 8'h86);
        vcc_good <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk8({7'h00, rst_pin_oe_b}, 8'h00);
        vcc_good <= 1'b1;
        wait_lvl(0, 1'b1, 60, n);
        chk_rng(n, 0, 6);
        reg_wr(`RTP_CTRL_ADDR, 8'h06);
        $display("test supply supervisor done");
        // a bounce shorter than the debounce time draws no pulse
        pb_b <= 1'b0;
        repeat (10) @(posedge sys_clk);
        pb_b <= 1'b1;
        cnt_low(0, 40, n);
        chk_rng(n, 0, 0);
        pb_b <= 1'b0;
        wait_lvl(0, 1'b0, 60, n);
        chk_rng(n, PBDB, PBDB + 8);
        pb_b <= 1'b1;
        wait_lvl(0, 1'b1, 60, n);
        chk_rng(n, REC - 1, REC + 2);
        $display("test pushbutton done");
        close_out;
    end
endmodule : test_rtc_output_pins_and_reset
